// ---- amplifier_autorange_control.sv ----
`include "amplifier_consts.svh"

module amplifier_autorange_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Amplifier side
  input wire amp_autorange_pkg::sample_s sample_in,
  output amp_autorange_pkg::range_ctl_s amp_range
);
  import amp_autorange_pkg::*;

  ctl_state_s s_q;
  ctl_state_s s_d;

  logic avg_done;
  logic [20:0] avg_sum;
  logic [31:0] sum_pct;
  logic [31:0] lo_thr;
  logic [31:0] up_thr;
  logic below;
  logic above;
  logic [3:0] step_next;
  logic req;
  logic accept;
  logic wr_ctrl;
  logic wr_limits;
  logic wr_settle;
  logic wr_status;
  logic [6:0] w_lower;
  logic [6:0] w_upper;
  logic [5:0] w_settle;
  logic [3:0] w_manual;

  settle_averager u_avg (
    .clock(clock),
    .rst_n(rst_n),
    .clear(s_q.restart),
    .settle_count(s_q.settle),
    .sample_in(sample_in),
    .done(avg_done),
    .sum(avg_sum)
  );

  range_stepper u_step (
    .current(s_q.range),
    .mode(s_q.mode),
    .step_up(above),
    .step_down(below),
    .next(step_next)
  );

  // Percent compare scaled by count and full scale, so no divide is needed
  assign sum_pct = 32'(avg_sum) * 32'(`PCT_FULL);
  assign lo_thr = 32'(s_q.lower) * 32'(`FULL_SCALE) * 32'(s_q.settle);
  assign up_thr = 32'(s_q.upper) * 32'(`FULL_SCALE) * 32'(s_q.settle);
  assign below = sum_pct < lo_thr;
  assign above = sum_pct > up_thr;

  // Every access takes two cycles: waitrequest high, then low with data
  assign req = avs_read || avs_write;
  assign accept = req && s_q.ack;
  assign wr_ctrl = accept && avs_write && avs_address == `OFS_CTRL;
  assign wr_limits = accept && avs_write && avs_address == `OFS_LIMITS;
  assign wr_settle = accept && avs_write && avs_address == `OFS_SETTLE;
  assign wr_status = accept && avs_write && avs_address == `OFS_STATUS;
  assign w_lower = avs_writedata[`LIM_LO_MSB:`LIM_LO_LSB];
  assign w_upper = avs_writedata[`LIM_UP_MSB:`LIM_UP_LSB];
  assign w_settle = avs_writedata[`SETTLE_MSB:`SETTLE_LSB];
  assign w_manual = avs_writedata[`CTRL_MAN_MSB:`CTRL_MAN_LSB];

  always_comb begin
    s_d = s_q;
    s_d.changed = 1'b0;
    s_d.restart = 1'b0;
    s_d.ack = req && !s_q.ack;

    if (avg_done) begin
      s_d.last_sum = avg_sum;
    end
    // Decisions only come from a full settle block while auto is on
    if (avg_done && s_q.auto_en) begin
      if (step_next != s_q.range) begin
        s_d.range = step_next;
        s_d.changed = 1'b1;
        s_d.restart = 1'b1;
      end
    end

    // A manual range write that differs from the current range wins over a decision in the same cycle
    if (wr_ctrl) begin
      s_d.auto_en = avs_writedata[`CTRL_AUTO_BIT];
      s_d.mode = step_mode_e'(avs_writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      s_d.restart = 1'b1;
      if (!avs_writedata[`CTRL_AUTO_BIT] && w_manual >= `RANGE_LOW &&
          w_manual <= `RANGE_HIGH && w_manual != s_q.range) begin
        s_d.range = w_manual;
        s_d.changed = 1'b1;
      end
    end
    if (wr_status && avs_writedata[`STAT_REJECT_BIT]) begin
      s_d.reject = 1'b0;
    end
    // Flag sets are placed after the clear so a set always wins
    if (wr_limits) begin
      if (w_upper > w_lower && w_upper <= `PCT_FULL) begin
        s_d.lower = w_lower;
        s_d.upper = w_upper;
      end else begin
        s_d.reject = 1'b1;
      end
    end
    if (wr_settle) begin
      if (w_settle >= `SETTLE_MIN && w_settle <= `SETTLE_MAX) begin
        s_d.settle = w_settle;
        s_d.restart = 1'b1;
      end else begin
        s_d.reject = 1'b1;
      end
    end

    // Read data is captured in the waitrequest cycle and held while ack
    if (req && !s_q.ack) begin
      s_d.rdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          `OFS_CTRL: begin
            s_d.rdata[`CTRL_AUTO_BIT] = s_q.auto_en;
            s_d.rdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = s_q.mode;
            s_d.rdata[`CTRL_MAN_MSB:`CTRL_MAN_LSB] = s_q.range;
          end
          `OFS_LIMITS: begin
            s_d.rdata[`LIM_LO_MSB:`LIM_LO_LSB] = s_q.lower;
            s_d.rdata[`LIM_UP_MSB:`LIM_UP_LSB] = s_q.upper;
          end
          `OFS_SETTLE: begin
            s_d.rdata[`SETTLE_MSB:`SETTLE_LSB] = s_q.settle;
          end
          `OFS_STATUS: begin
            s_d.rdata[`STAT_RANGE_MSB:`STAT_RANGE_LSB] = s_q.range;
            s_d.rdata[`STAT_REJECT_BIT] = s_q.reject;
            s_d.rdata[`STAT_AUTO_BIT] = s_q.auto_en;
          end
          `OFS_SUM: begin
            s_d.rdata = 32'(s_q.last_sum);
          end
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= STEP_ALL;
      s_q.lower <= `RST_LOWER;
      s_q.upper <= `RST_UPPER;
      s_q.settle <= `RST_SETTLE;
      s_q.range <= `RST_RANGE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = req && !s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign amp_range.number = s_q.range;
  assign amp_range.changed = s_q.changed;

  property p_manual_hold;
    @(posedge clock) disable iff (!rst_n)
    !s_q.auto_en && !wr_ctrl |=> $stable(s_q.range);
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("range moved while auto ranging was off");

  property p_step_down_all;
    @(posedge clock) disable iff (!rst_n)
    avg_done && s_q.auto_en && below && s_q.mode == STEP_ALL &&
      s_q.range > `RANGE_LOW && !wr_ctrl
      |=> s_q.range == 4'($past(s_q.range) - 4'h1) && s_q.changed;
  endproperty
  a_step_down_all: assert property (p_step_down_all)
    else $error("low average did not step one range down");

  property p_step_up_all;
    @(posedge clock) disable iff (!rst_n)
    avg_done && s_q.auto_en && above && s_q.mode == STEP_ALL &&
      s_q.range < `RANGE_HIGH && !wr_ctrl
      |=> s_q.range == 4'($past(s_q.range) + 4'h1) && s_q.changed;
  endproperty
  a_step_up_all: assert property (p_step_up_all)
    else $error("high average did not step one range up");

  property p_inside_limits;
    @(posedge clock) disable iff (!rst_n)
    avg_done && s_q.auto_en && !wr_ctrl &&
      32'(avg_sum) * 32'h0000_0064 >= lo_thr &&
      32'(avg_sum) * 32'h0000_0064 <= up_thr
      |=> $stable(s_q.range);
  endproperty
  a_inside_limits: assert property (p_inside_limits)
    else $error("range changed with average inside the limits");

  property p_odd_skip;
    @(posedge clock) disable iff (!rst_n)
    avg_done && s_q.auto_en && below && s_q.mode == STEP_ODD &&
      s_q.range == 4'h5 && !wr_ctrl |=> s_q.range == 4'h3;
  endproperty
  a_odd_skip: assert property (p_odd_skip)
    else $error("odd mode did not skip the even range");

  property p_limits_refused;
    @(posedge clock) disable iff (!rst_n)
    wr_limits && w_lower >= w_upper
      |=> s_q.reject && $stable(s_q.lower) && $stable(s_q.upper);
  endproperty
  a_limits_refused: assert property (p_limits_refused)
    else $error("inverted limits were accepted or not flagged");

  property p_settle_bounds;
    @(posedge clock) disable iff (!rst_n)
    s_q.settle >= 6'h02 && s_q.settle <= 6'h20;
  endproperty
  a_settle_bounds: assert property (p_settle_bounds)
    else $error("settle count outside 2 to 32");

  property p_range_clamp;
    @(posedge clock) disable iff (!rst_n)
    avg_done && s_q.auto_en && above && s_q.range == 4'h8 && !wr_ctrl
      |=> s_q.range == 4'h8 && !s_q.changed;
  endproperty
  a_range_clamp: assert property (p_range_clamp)
    else $error("range wrapped past the highest range");

  property p_fresh_average;
    @(posedge clock) disable iff (!rst_n)
    s_q.changed |-> s_q.restart ##1 !avg_done ##1 !avg_done;
  endproperty
  a_fresh_average: assert property (p_fresh_average)
    else $error("decision made without a fresh settle block");

endmodule

// ---- amplifier_consts.svh ----
`ifndef AMPLIFIER_CONSTS_SVH
`define AMPLIFIER_CONSTS_SVH

// Register byte offsets
`define OFS_CTRL 5'h00
`define OFS_LIMITS 5'h04
`define OFS_SETTLE 5'h08
`define OFS_STATUS 5'h0c
`define OFS_SUM 5'h10

// Field positions
`define CTRL_AUTO_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define CTRL_MAN_LSB 4
`define CTRL_MAN_MSB 7
`define LIM_LO_LSB 0
`define LIM_LO_MSB 6
`define LIM_UP_LSB 8
`define LIM_UP_MSB 14
`define SETTLE_LSB 0
`define SETTLE_MSB 5
`define STAT_RANGE_LSB 0
`define STAT_RANGE_MSB 3
`define STAT_REJECT_BIT 8
`define STAT_AUTO_BIT 12

// Reset values and limits
`define RST_LOWER 7'h0f
`define RST_UPPER 7'h55
`define RST_SETTLE 6'h04
`define SETTLE_MIN 6'h02
`define SETTLE_MAX 6'h20
`define PCT_FULL 7'h64
`define FULL_SCALE 16'hffff
`define RANGE_LOW 4'h1
`define RANGE_HIGH 4'h8
`define RST_RANGE 4'h1

`endif

// ---- amp_autorange_pkg.sv ----
package amp_autorange_pkg;

  typedef enum logic [1:0] {STEP_ALL, STEP_ODD, STEP_EVEN} step_mode_e;

  // One relative-signal sample from the amplifier's converter
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } sample_s;

  // Range selection driven to the current_input_amplifier
  typedef struct packed {
    logic [3:0] number;
    logic changed;
  } range_ctl_s;

  typedef struct packed {
    logic [20:0] acc;
    logic [5:0] cnt;
    logic done;
    logic [20:0] sum;
  } avg_state_s;

  typedef struct packed {
    logic auto_en;
    step_mode_e mode;
    logic [6:0] lower;
    logic [6:0] upper;
    logic [5:0] settle;
    logic [3:0] range;
    logic changed;
    logic restart;
    logic reject;
    logic [20:0] last_sum;
    logic ack;
    logic [31:0] rdata;
  } ctl_state_s;

endpackage

// ---- settle_averager.sv ----
`include "amplifier_consts.svh"

module settle_averager (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [5:0] settle_count,
  // Samples in
  input wire amp_autorange_pkg::sample_s sample_in,
  // Block result
  output logic done,
  output logic [20:0] sum
);
  import amp_autorange_pkg::*;

  avg_state_s s_q;
  avg_state_s s_d;

  // A sum instead of a mean keeps a divider out; the caller scales instead
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (clear) begin
      s_d.acc = '0;
      s_d.cnt = '0;
    end else if (sample_in.valid) begin
      if (6'(s_q.cnt + 6'h01) >= settle_count) begin
        s_d.sum = s_q.acc + 21'(sample_in.value);
        s_d.done = 1'b1;
        s_d.acc = '0;
        s_d.cnt = '0;
      end else begin
        s_d.acc = s_q.acc + 21'(sample_in.value);
        s_d.cnt = 6'(s_q.cnt + 6'h01);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign sum = s_q.sum;

  property p_block_complete;
    @(posedge clock) disable iff (!rst_n)
    s_q.done |-> $past(sample_in.valid) && !$past(clear) &&
      ($past(s_q.cnt) == 6'($past(settle_count) - 6'h01));
  endproperty
  a_block_complete: assert property (p_block_complete)
    else $error("average finished before the settle count was reached");

endmodule

// ---- range_stepper.sv ----
`include "amplifier_consts.svh"

module range_stepper (
  // Current selection
  input wire logic [3:0] current,
  input wire amp_autorange_pkg::step_mode_e mode,
  // Requests
  input wire logic step_up,
  input wire logic step_down,
  // Result
  output logic [3:0] next
);
  import amp_autorange_pkg::*;

  logic [3:0] lo;
  logic [3:0] hi;
  logic [3:0] step;
  logic [3:0] cand;
  logic match;

  always_comb begin
    unique case (mode)
      STEP_ODD: begin
        lo = `RANGE_LOW;
        hi = `RANGE_HIGH - 4'h1;
        match = current[0];
      end
      STEP_EVEN: begin
        lo = `RANGE_LOW + 4'h1;
        hi = `RANGE_HIGH;
        match = !current[0];
      end
      // Code 3 is unused and behaves as all ranges
      default: begin
        lo = `RANGE_LOW;
        hi = `RANGE_HIGH;
        match = 1'b0;
      end
    endcase
    // Off-parity start lands on the nearest range of the right parity
    step = match ? 4'h2 : 4'h1;
    cand = current;
    next = current;
    if (step_up) begin
      if (current < hi) begin
        cand = 4'(current + step);
        next = (cand > hi) ? hi : cand;
      end
    end else if (step_down) begin
      if (current > lo) begin
        cand = 4'(current - step);
        next = (cand < lo || cand > current) ? lo : cand;
      end
    end
  end

endmodule

// ---- amplifier_model.sv ----
module amplifier_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench controls
  input wire logic [15:0] level,
  input wire logic [1:0] gap,
  input wire logic alt,
  // Converter output
  output amp_autorange_pkg::sample_s sample_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import amp_autorange_pkg::*;

  logic [1:0] cnt_q;
  logic flip_q;

  // Between samples the data lines invert every cycle, so gaps of 2 or more show the last value again
  always @(posedge clock) begin
    if (!rst_n) begin
      sample_in <= '0;
      cnt_q <= gap;
      flip_q <= 1'b0;
    end else begin
      sample_in.valid <= cnt_q == 2'h0;
      if (cnt_q == 2'h0) begin
        cnt_q <= gap;
        sample_in.value <= (alt && flip_q) ? ~level : level;
        flip_q <= ~flip_q;
      end else begin
        cnt_q <= cnt_q - 2'h1;
        sample_in.value <= ~sample_in.value;
      end
    end
  end
endmodule

// ---- amplifier_autorange_control_tb.sv ----
module amplifier_autorange_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import amp_autorange_pkg::*;

  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, alt;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] level;
  logic [1:0] gap;
  logic [3:0] last_num, exp_num;
  sample_s sample_in;
  range_ctl_s amp_range;
  step_mode_e mode;
  int fail_count, checked, dir, settle, cnt, n;
  logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14};
  logic [31:0] re [5] = '{32'h10, 32'h550f, 32'h4, 32'h1, 32'h0};
  logic [5:0] sv [4] = '{6'h01, 6'h02, 6'h21, 6'h20};
  logic [5:0] se [4] = '{6'h04, 6'h02, 6'h02, 6'h20};

  amplifier_autorange_control amplifier_autorange_control_inst (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_in(sample_in),
    .amp_range(amp_range));

  amplifier_model amplifier_model_inst (
    .clock(clock), .rst_n(rst_n), .level(level), .gap(gap), .alt(alt),
    .sample_in(sample_in));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic compare_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected reg at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic compare_range(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected range at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] step_fn(input logic [3:0] c, input logic up);
    logic [3:0] lo, hi, s, nx;
    lo = (mode == STEP_EVEN) ? 4'h2 : 4'h1;
    hi = (mode == STEP_ODD) ? 4'h7 : 4'h8;
    s = (mode == STEP_ALL || c[0] != (mode == STEP_ODD)) ? 4'h1 : 4'h2;
    nx = up ? c + s : c - s;
    return (nx > hi || nx < lo) ? c : nx;
  endfunction

  // Waitrequest and read data are read as the rising edge wakes us, before
  // the design's flops move, so they are the values that edge samples
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50) fail_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    compare_reg(rd, e);
  endtask

  task automatic wait_range(input logic [3:0] t);
    n = 0;
    while (amp_range.number !== t && n < 3000) begin
      @(negedge clock);
      n++;
    end
    compare_range(amp_range.number, t);
  endtask

  task automatic run(input logic [1:0] m, input logic [15:0] lv,
                     input int d, input logic [3:0] t);
    dir = 0;
    bus(1'b1, 5'h00, {29'h0, m, 1'b0});
    mode = step_mode_e'(m);
    level <= lv;
    gap <= 2'($urandom_range(0, 3));
    // Let the old level drain out of the averager before auto goes on
    repeat (8) @(posedge clock);
    dir = d;
    bus(1'b1, 5'h00, {29'h0, m, 1'b1});
    wait_range(t);
    repeat (60) @(negedge clock);
    compare_range(amp_range.number, t);
    $display("test stepping mode %0d done", m);
  endtask

  // Every range change is checked against the number of samples gathered
  // since the previous change, and against the stepping order while dir is nonzero
  always @(negedge clock) begin
    if (rst_n && amp_range.changed === 1'b1) begin
      if (dir != 0) begin
        exp_num = step_fn(last_num, dir == 1);
        compare_range(amp_range.number, exp_num);
      end
      compare_reg(32'(cnt >= settle), 32'h1);
      cnt = 0;
    end else if (sample_in.valid === 1'b1) begin
      cnt++;
    end
    last_num = amp_range.number;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    level = 16'h0;
    gap = 2'h0;
    alt = 1'b0;
    dir = 0;
    settle = 4;
    cnt = 0;
    mode = STEP_ALL;
    void'($urandom(91733));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], re[i]);
    $display("test reset values done");
    level <= 16'hffff;
    repeat (40) @(posedge clock);
    rd_chk(5'h0c, 32'h1);
    rd_chk(5'h10, 32'h0003_fffc);
    $display("test auto off done");
    run(2'h0, 16'hffff, 1, 4'h8);
    run(2'h0, 16'h0, 2, 4'h1);
    run(2'h1, 16'hffff, 1, 4'h7);
    run(2'h1, 16'h0, 2, 4'h1);
    run(2'h2, 16'hffff, 1, 4'h8);
    run(2'h2, 16'h0, 2, 4'h2);
    dir = 0;
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h04, 32'h505a);
    rd_chk(5'h04, 32'h550f);
    bus(1'b0, 5'h0c, 32'h0);
    compare_reg(32'(rd[8]), 32'h1);
    bus(1'b1, 5'h0c, 32'h100);
    rd_chk(5'h0c, 32'h2);
    bus(1'b1, 5'h04, 32'h3232);
    rd_chk(5'h04, 32'h550f);
    foreach (sv[i]) begin
      bus(1'b1, 5'h08, {26'h0, sv[i]});
      settle = int'(se[i]);
      rd_chk(5'h08, {26'h0, se[i]});
    end
    $display("test refusals done");
    bus(1'b1, 5'h08, 32'h2);
    settle = 2;
    bus(1'b1, 5'h04, 32'h3c28);
    bus(1'b1, 5'h00, 32'h50);
    rd_chk(5'h00, 32'h50);
    mode = STEP_ALL;
    level <= 16'(27000 + $urandom_range(0, 11000));
    repeat (8) @(posedge clock);
    bus(1'b1, 5'h00, 32'h1);
    repeat (60) begin
      @(posedge clock);
      level <= 16'(27000 + $urandom_range(0, 11000));
    end
    bus(1'b0, 5'h0c, 32'h0);
    compare_range(rd[3:0], 4'h5);
    bus(1'b1, 5'h00, 32'h0);
    gap <= 2'h0;
    level <= 16'hffff;
    alt <= 1'b1;
    repeat (8) @(posedge clock);
    bus(1'b1, 5'h00, 32'h1);
    repeat (50) @(posedge clock);
    bus(1'b0, 5'h0c, 32'h0);
    compare_range(rd[3:0], 4'h5);
    bus(1'b1, 5'h00, 32'h0);
    alt <= 1'b0;
    level <= 16'h9eb8;
    repeat (8) @(posedge clock);
    dir = 1;
    bus(1'b1, 5'h00, 32'h1);
    wait_range(4'h6);
    $display("test averaging and limits done");
    close_out();
  end
endmodule
